// ===== tsa_pkg.sv
// package for the tag state and anticollision controller
// assumes a decoded command strobe from a frame decoder on the same clock
package tsa_pkg;

  // ****************************************
  // command encodings seen by this block
  // ****************************************
  localparam logic [7:0] TSA_INV_START_B0 = 8'h06;  // first byte of inventory start
  localparam logic [7:0] TSA_INV_START_B1 = 8'h00;  // second byte of inventory start

  // decoded command kinds, one code per command class
  typedef enum logic [3:0] {
    TSA_CMD_INV_START,
    TSA_CMD_POLL16,
    TSA_CMD_PROBE,
    TSA_CMD_READ_BLK,
    TSA_CMD_WRITE_BLK,
    TSA_CMD_FETCH_SERIAL,
    TSA_CMD_RETURN_CENSUS,
    TSA_CMD_CHOOSE,
    TSA_CMD_RETIRE,
    TSA_CMD_OTHER
  } tsa_cmd_t;

  // tag states
  typedef enum logic [2:0] {
    TSA_ST_OFF,
    TSA_ST_READY,
    TSA_ST_INVENTORY,
    TSA_ST_SELECTED,
    TSA_ST_DESELECTED,
    TSA_ST_DEACTIVATED
  } tsa_state_t;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam int           TSA_HANDLE_W    = 8;      // handle width, 256 tags
  localparam int           TSA_LANE_W      = 4;      // answer slot width, 16 slots
  localparam logic [15:0]  TSA_LFSR_SEED   = 16'hACE1;
  localparam logic [15:0]  TSA_LFSR_TAPS   = 16'hB400;
  localparam logic [7:0]   TSA_HANDLE_RST  = 8'h00;

endpackage : tsa_pkg

// ===== tsa_core.sv
// command state controller and slotted anticollision of a contactless tag
// assumes cmd_valid is a one-cycle strobe from a decoder on ref_clk and
// field_ok is an asynchronous level from the analog front end
`timescale 1ns/1ns

module tsa_core
  import tsa_pkg::*;
(
  input  wire logic                    ref_clk,        // 50 MHz system clock
  input  wire logic                    srst,           // synchronous reset, active high
  input  wire logic                    field_ok,       // field strong enough, asynchronous
  input  wire logic                    cmd_valid,      // one-cycle decoded command strobe
  input  wire logic [7:0]              cmd_byte0,      // first command byte
  input  wire logic [7:0]              cmd_byte1,      // second command byte
  input  wire tsa_cmd_t                cmd_kind,       // decoded command class
  input  wire logic [TSA_HANDLE_W-1:0] cmd_handle,     // handle carried by choose
  input  wire logic [TSA_LANE_W-1:0]   lane_index,     // slot index carried by probe
  output logic                         answer_valid,   // one-cycle answer strobe
  output logic [TSA_HANDLE_W-1:0]      answer_handle,  // handle returned
  output logic                         exec_valid,     // one-cycle memory command grant
  output tsa_cmd_t                     exec_kind,      // memory command granted
  output tsa_state_t                   tag_state,      // current tag state
  output logic [TSA_HANDLE_W-1:0]      tag_handle      // current handle
);

  // ****************************************
  // field level synchroniser
  // ****************************************
  logic field_s1_r;   // first stage, read only by the second
  logic field_s2_r;   // second stage
  logic field_s3_r;   // third stage
  logic field_q_r;    // accepted level

  // a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      field_s1_r <= 1'b0;
      field_s2_r <= 1'b0;
      field_s3_r <= 1'b0;
      field_q_r  <= 1'b0;
    end else begin
      field_s1_r <= field_ok;
      field_s2_r <= field_s1_r;
      field_s3_r <= field_s2_r;
      if (field_s2_r == field_s3_r) begin
        field_q_r <= field_s3_r;
      end
    end
  end

  // ****************************************
  // random source
  // ****************************************
  logic [15:0] lfsr_r;     // free-running galois lfsr
  logic [15:0] lfsr_nxt;   // next lfsr value

  // runs every cycle so command arrival time adds entropy between tags
  assign lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ TSA_LFSR_TAPS) : (lfsr_r >> 1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lfsr_r <= TSA_LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  tsa_state_t                state_r;        // tag state
  tsa_state_t                state_nxt;      // next tag state
  logic [TSA_HANDLE_W-1:0]   handle_r;
  logic [TSA_HANDLE_W-1:0]   handle_nxt;     // next handle
  logic                      ans_nxt;        // answer this cycle
  logic                      exec_nxt;       // grant memory command
  logic                      field_rise;     // field just became strong
  logic                      is_start;       // inventory start, bytes checked
  logic                      is_poll;        // sixteen-lane poll
  logic                      is_probe;       // lane probe
  logic                      is_choose;      // choose-tag
  logic                      is_mem;         // memory or serial command
  logic                      handle_hit;     // choose handle equals own
  logic [TSA_LANE_W-1:0]     new_lane;       // fresh random slot
  logic                      lane_hit;       // probe slot equals own
  logic [TSA_HANDLE_W-1:0]   lfsr_handle;    // random draw offered to the handle
  logic [TSA_HANDLE_W-TSA_LANE_W-1:0] handle_upper;  // handle bits above the slot

  assign field_rise = field_s3_r & ~field_q_r & (field_s2_r == field_s3_r);
  assign is_start   = cmd_valid & (cmd_kind == TSA_CMD_INV_START)
                    & (cmd_byte0 == TSA_INV_START_B0) & (cmd_byte1 == TSA_INV_START_B1);
  assign is_poll    = cmd_valid & (cmd_kind == TSA_CMD_POLL16);
  assign is_probe   = cmd_valid & (cmd_kind == TSA_CMD_PROBE);
  assign is_choose  = cmd_valid & (cmd_kind == TSA_CMD_CHOOSE);
  assign is_mem     = cmd_valid & ((cmd_kind == TSA_CMD_READ_BLK) | (cmd_kind == TSA_CMD_WRITE_BLK)
                    | (cmd_kind == TSA_CMD_FETCH_SERIAL));
  assign handle_hit = (cmd_handle == handle_r);
  assign new_lane   = lfsr_r[TSA_LANE_W-1:0];
  assign lane_hit   = (lane_index == handle_r[TSA_LANE_W-1:0]);
  assign lfsr_handle  = lfsr_r[TSA_HANDLE_W-1:0];
  assign handle_upper = handle_r[TSA_HANDLE_W-1:TSA_LANE_W];

  // ****************************************
  // state transitions and answers
  // ****************************************
  // field loss wins over any command in the same cycle
  always_comb begin
    state_nxt  = state_r;
    handle_nxt = handle_r;
    ans_nxt    = 1'b0;
    exec_nxt   = 1'b0;
    if (!field_q_r && !field_rise) begin
      state_nxt = TSA_ST_OFF;
    end else if (field_rise) begin
      state_nxt  = TSA_ST_READY;
      handle_nxt = lfsr_r[TSA_HANDLE_W-1:0];
    end else begin
      unique case (state_r)
        TSA_ST_OFF: begin
          state_nxt = TSA_ST_READY;
        end
        TSA_ST_READY: begin
          // poll, probe and all else are dropped here
          if (is_start) begin
            state_nxt  = TSA_ST_INVENTORY;
            handle_nxt = lfsr_r[TSA_HANDLE_W-1:0];
            ans_nxt    = 1'b1;
          end
        end
        TSA_ST_INVENTORY: begin
          if (is_start) begin
            handle_nxt = lfsr_r[TSA_HANDLE_W-1:0];
            ans_nxt    = 1'b1;
          end else if (is_poll) begin
            handle_nxt = {handle_r[TSA_HANDLE_W-1:TSA_LANE_W], new_lane};
            ans_nxt    = (new_lane == '0);
          end else if (is_probe) begin
            ans_nxt = lane_hit;
          end else if (is_choose && handle_hit) begin
            state_nxt = TSA_ST_SELECTED;
          end
        end
        TSA_ST_SELECTED: begin
          if (is_mem) begin
            exec_nxt = 1'b1;
          end else if (is_choose && !handle_hit) begin
            state_nxt = TSA_ST_DESELECTED;
          end else if (cmd_valid && cmd_kind == TSA_CMD_RETIRE) begin
            state_nxt = TSA_ST_DEACTIVATED;
          end else if (cmd_valid && cmd_kind == TSA_CMD_RETURN_CENSUS) begin
            state_nxt = TSA_ST_INVENTORY;
          end
        end
        TSA_ST_DESELECTED: begin
          if (is_choose && handle_hit) begin
            state_nxt = TSA_ST_SELECTED;
          end
        end
        TSA_ST_DEACTIVATED: begin
          state_nxt = TSA_ST_DEACTIVATED;
        end
        default: begin
          state_nxt = TSA_ST_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // state registers and outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r       <= TSA_ST_OFF;
      handle_r      <= TSA_HANDLE_RST;
      answer_valid  <= 1'b0;
      answer_handle <= TSA_HANDLE_RST;
      exec_valid    <= 1'b0;
      exec_kind     <= TSA_CMD_OTHER;
    end else begin
      state_r       <= state_nxt;
      handle_r      <= handle_nxt;
      answer_valid  <= ans_nxt;
      answer_handle <= handle_nxt;
      exec_valid    <= exec_nxt;
      exec_kind     <= exec_nxt ? cmd_kind : TSA_CMD_OTHER;
    end
  end

  assign tag_state  = state_r;
  assign tag_handle = handle_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_start_in_ready;
    state_r == TSA_ST_READY && is_start && field_q_r && !field_rise;
  endsequence

  a_ready_to_inv: assert property (@(posedge ref_clk) disable iff (srst)
    s_start_in_ready |=> state_r == TSA_ST_INVENTORY && answer_valid) else $error("start not taken");
  a_ready_ignores: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_READY && field_q_r && !is_start |=> state_r == TSA_ST_READY) else $error("ready left");
  a_deact_stays: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_DEACTIVATED && field_q_r |=> state_r == TSA_ST_DEACTIVATED) else $error("deact left");
  a_probe_answer: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_INVENTORY && field_q_r && is_probe |=> answer_valid == $past(lane_hit)) else $error("probe");
  a_poll_zero: assert property (@(posedge ref_clk) disable iff (srst)
    answer_valid && $past(is_poll) |-> handle_r[3:0] == 4'h0) else $error("poll answer nonzero slot");
  a_sel_silent: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_SELECTED |=> !answer_valid) else $error("selected answered");
  a_choose_match: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_INVENTORY && field_q_r && is_choose && handle_hit |=> state_r == TSA_ST_SELECTED)
    else $error("choose failed");
  a_off_silent: assert property (@(posedge ref_clk) disable iff (srst)
    !field_q_r |=> !answer_valid && !exec_valid) else $error("off answered");
  a_retire: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_SELECTED && field_q_r && cmd_valid && cmd_kind == TSA_CMD_RETIRE
    |=> state_r == TSA_ST_DEACTIVATED) else $error("retire failed");

  // ****************************************
  // selection and anticollision checks
  // ****************************************
  // a choose carrying another handle while selected
  sequence s_foreign_in_sel;
    state_r == TSA_ST_SELECTED && field_q_r && is_choose && !handle_hit;
  endsequence

  // a choose carrying the own handle while deselected
  sequence s_match_in_desel;
    state_r == TSA_ST_DESELECTED && field_q_r && is_choose && handle_hit;
  endsequence

  // a memory command while selected
  sequence s_mem_in_sel;
    state_r == TSA_ST_SELECTED && field_q_r && is_mem;
  endsequence

  // a start while already in inventory
  sequence s_start_in_inv;
    state_r == TSA_ST_INVENTORY && field_q_r && is_start;
  endsequence

  // another handle chosen means this tag must step aside
  a_foreign_desel: assert property (@(posedge ref_clk) disable iff (srst)
    s_foreign_in_sel |=> state_r == TSA_ST_DESELECTED) else $error("foreign choose kept selection");
  // only the own handle brings a deselected tag back
  a_desel_rechoose: assert property (@(posedge ref_clk) disable iff (srst)
    s_match_in_desel |=> state_r == TSA_ST_SELECTED) else $error("matching choose not taken");
  // anything else leaves a deselected tag silent and put
  a_desel_ignores: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_DESELECTED && field_q_r && !(is_choose && handle_hit)
    |=> state_r == TSA_ST_DESELECTED && !answer_valid && !exec_valid) else $error("deselected reacted");
  // memory commands are granted with their own kind
  a_mem_grant: assert property (@(posedge ref_clk) disable iff (srst)
    s_mem_in_sel |=> exec_valid && exec_kind == $past(cmd_kind)) else $error("memory command not granted");
  // a repeated start redraws the handle and answers with it
  a_start_redraw: assert property (@(posedge ref_clk) disable iff (srst)
    s_start_in_inv |=> handle_r == $past(lfsr_handle) && answer_valid) else $error("start did not redraw");
  // a poll only touches the slot nibble
  a_poll_keeps_high: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_INVENTORY && field_q_r && is_poll |=> handle_upper == $past(handle_upper))
    else $error("poll changed upper handle");
  // return-to-census drops a selected tag back to inventory
  a_census_back: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_SELECTED && field_q_r && cmd_valid && cmd_kind == TSA_CMD_RETURN_CENSUS
    |=> state_r == TSA_ST_INVENTORY) else $error("census return failed");
  // a tag still in ready stays out of slotted rounds
  a_ready_no_poll: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_READY && (is_poll || is_probe) |=> !answer_valid) else $error("ready tag answered poll");
  // field entry lands in ready with a fresh draw
  a_rise_ready: assert property (@(posedge ref_clk) disable iff (srst)
    field_rise |=> state_r == TSA_ST_READY && handle_r == $past(lfsr_handle)) else $error("field entry missed");
  // anticollision commands keep the tag in inventory
  a_inv_stays: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_INVENTORY && field_q_r && (is_start || is_poll || is_probe)
    |=> state_r == TSA_ST_INVENTORY) else $error("inventory left on anticollision");
  // a probe never alters the slot it is judged against
  a_probe_keeps: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TSA_ST_INVENTORY && field_q_r && is_probe |=> handle_r == $past(handle_r))
    else $error("probe changed handle");

endmodule // tsa_core

// ===== tsa_reader.sv
// reader model: issues decoded commands to the tag controller
// assumes the bench calls send from one process, one command at a time
`timescale 1ns/1ns
module tsa_reader
  import tsa_pkg::*;
(
  input  wire logic  ref_clk,     // system clock
  output logic       cmd_valid,   // one-cycle command strobe
  output logic [7:0] cmd_byte0,   // first command byte
  output logic [7:0] cmd_byte1,   // second command byte
  output tsa_cmd_t   cmd_kind,    // decoded class
  output logic [7:0] cmd_handle,  // handle carried by choose
  output logic [3:0] lane_index   // slot carried by probe
);
  // idle lines start as junk so nothing stale looks like a command
  initial begin
    cmd_valid  = 1'b0;
    cmd_byte0  = 8'hA5;
    cmd_byte1  = 8'h5A;
    cmd_kind   = TSA_CMD_OTHER;
    cmd_handle = 8'h3C;
    lane_index = 4'h9;
  end

  // one command, held for exactly the sampling edge, then strobe dropped and byte, handle and slot lines inverted, kind kept
  task automatic send(input tsa_cmd_t k, input logic [7:0] b1, input logic [7:0] h, input logic [3:0] l);
    @(posedge ref_clk);
    #1;
    cmd_valid  = 1'b1;
    cmd_kind   = k;
    cmd_byte0  = (k == TSA_CMD_PROBE) ? {l, 4'h6} : 8'h06;
    cmd_byte1  = b1;
    cmd_handle = h;
    lane_index = l;
    @(posedge ref_clk);
    #1;
    cmd_valid  = 1'b0;
    cmd_byte0  = ~cmd_byte0;
    cmd_byte1  = ~cmd_byte1;
    cmd_handle = ~cmd_handle;
    lane_index = ~lane_index;
  endtask
endmodule  // tsa_reader

// ===== tb.sv
// self-checking bench for the tag state and anticollision controller
// assumes tsa_reader plays the reader; field_ok and srst come from here
`timescale 1ns/1ns
module tb
  import tsa_pkg::*;
;
  logic                    ref_clk;   // 50 MHz clock
  logic                    srst;      // sync reset
  logic                    field_ok;  // field level
  logic                    cmd_valid, answer_valid, exec_valid;
  logic [7:0]              cmd_byte0, cmd_byte1;
  tsa_cmd_t                cmd_kind, exec_kind;
  logic [TSA_HANDLE_W-1:0] cmd_handle, answer_handle, tag_handle;
  logic [TSA_LANE_W-1:0]   lane_index;
  tsa_state_t              tag_state;
  int                      fails = 0;    // mismatches
  int                      n_tests = 0;  // comparisons

  always #10 ref_clk = ~ref_clk;

  tsa_core u_dut (.ref_clk(ref_clk), .srst(srst), .field_ok(field_ok), .cmd_valid(cmd_valid),
    .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1), .cmd_kind(cmd_kind), .cmd_handle(cmd_handle),
    .lane_index(lane_index), .answer_valid(answer_valid), .answer_handle(answer_handle),
    .exec_valid(exec_valid), .exec_kind(exec_kind), .tag_state(tag_state), .tag_handle(tag_handle));
  tsa_reader u_rdr (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte0(cmd_byte0),
    .cmd_byte1(cmd_byte1), .cmd_kind(cmd_kind), .cmd_handle(cmd_handle), .lane_index(lane_index));

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic stop_test();
    $display("n_tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // send one command, judge the registered reply in the cycle after
  task automatic issue(input tsa_cmd_t k, input logic [7:0] h, input logic [3:0] l,
                       input logic ea, input logic ee, input tsa_state_t es);
    u_rdr.send(k, (k == TSA_CMD_POLL16) ? 8'h04 : 8'h00, h, l);
    chk("answer_valid", 16'(answer_valid), 16'(ea));
    if (ea) chk("answer_handle", 16'(answer_handle), 16'(tag_handle));
    chk("exec_valid", 16'(exec_valid), 16'(ee));
    if (ee) chk("exec_kind", 16'(exec_kind), 16'(k));
    chk("tag_state", 16'(tag_state), 16'(es));
  endtask

  // field changes pass a synchroniser, so allow a few cycles
  task automatic wait_state(input tsa_state_t es);
    for (int i = 0; i < 8 && tag_state !== es; i++) @(posedge ref_clk);
    #1;
    chk("wait tag_state", 16'(tag_state), 16'(es));
    if (tag_state !== es) stop_test();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power();
    issue(TSA_CMD_INV_START, 8'h00, 4'h0, 1'b0, 1'b0, TSA_ST_OFF);
    field_ok = 1'b1;
    wait_state(TSA_ST_READY);
  endtask

  // ready: everything but a well-formed start is ignored
  task automatic t_ready();
    for (int i = 1; i < 10; i++) issue(tsa_cmd_t'(4'(i)), tag_handle, 4'h0, 1'b0, 1'b0, TSA_ST_READY);
    u_rdr.send(TSA_CMD_INV_START, 8'h04, 8'h00, 4'h0);
    chk("bad start bytes", 16'(answer_valid), 16'h0);
    issue(TSA_CMD_INV_START, 8'h00, 4'h0, 1'b1, 1'b0, TSA_ST_INVENTORY);
  endtask

  // one polling round of sixteen slots, then choose the tag
  task automatic t_inventory();
    logic [3:0] hi;
    logic [3:0] lane;
    issue(TSA_CMD_INV_START, 8'h00, 4'h0, 1'b1, 1'b0, TSA_ST_INVENTORY);
    hi = tag_handle[7:4];
    u_rdr.send(TSA_CMD_POLL16, 8'h04, 8'h00, 4'h0);
    lane = tag_handle[3:0];
    chk("poll high nibble", 16'(tag_handle[7:4]), 16'(hi));
    chk("poll answer", 16'(answer_valid), 16'(lane == 4'h0));
    for (int s = 1; s < 16; s++) issue(TSA_CMD_PROBE, 8'h00, 4'(s), 4'(s) == lane, 1'b0, TSA_ST_INVENTORY);
    issue(TSA_CMD_CHOOSE, ~tag_handle, 4'h0, 1'b0, 1'b0, TSA_ST_INVENTORY);
    issue(TSA_CMD_CHOOSE, tag_handle, 4'h0, 1'b0, 1'b0, TSA_ST_SELECTED);
  endtask

  // selected, deselected, deactivated, then field cycling
  task automatic t_selected();
    logic [7:0] me;
    me = tag_handle;
    issue(TSA_CMD_POLL16, 8'h00, 4'h0, 1'b0, 1'b0, TSA_ST_SELECTED);
    issue(TSA_CMD_PROBE, 8'h00, me[3:0], 1'b0, 1'b0, TSA_ST_SELECTED);
    issue(TSA_CMD_INV_START, 8'h00, 4'h0, 1'b0, 1'b0, TSA_ST_SELECTED);
    for (int i = 3; i < 6; i++) issue(tsa_cmd_t'(4'(i)), me, 4'h0, 1'b0, 1'b1, TSA_ST_SELECTED);
    issue(TSA_CMD_RETURN_CENSUS, me, 4'h0, 1'b0, 1'b0, TSA_ST_INVENTORY);
    issue(TSA_CMD_CHOOSE, me, 4'h0, 1'b0, 1'b0, TSA_ST_SELECTED);
    issue(TSA_CMD_CHOOSE, me ^ 8'h01, 4'h0, 1'b0, 1'b0, TSA_ST_DESELECTED);
    issue(TSA_CMD_READ_BLK, me, 4'h0, 1'b0, 1'b0, TSA_ST_DESELECTED);
    issue(TSA_CMD_INV_START, 8'h00, 4'h0, 1'b0, 1'b0, TSA_ST_DESELECTED);
    issue(TSA_CMD_CHOOSE, me ^ 8'h80, 4'h0, 1'b0, 1'b0, TSA_ST_DESELECTED);
    issue(TSA_CMD_CHOOSE, me, 4'h0, 1'b0, 1'b0, TSA_ST_SELECTED);
    issue(TSA_CMD_RETIRE, me, 4'h0, 1'b0, 1'b0, TSA_ST_DEACTIVATED);
    for (int i = 0; i < 10; i++) issue(tsa_cmd_t'(4'(i)), me, me[3:0], 1'b0, 1'b0, TSA_ST_DEACTIVATED);
    field_ok = 1'b0;
    wait_state(TSA_ST_OFF);
    field_ok = 1'b1;
    wait_state(TSA_ST_READY);
  endtask

  // main sequence: reset two cycles, then each scenario in turn
  initial begin
    ref_clk  = 1'b0;
    srst     = 1'b1;
    field_ok = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    t_power();
    t_ready();
    t_inventory();
    t_selected();
    stop_test();
  end
endmodule  // tb
